// *** hdl/ssf_pkg.sv ***
// Purpose: Shared constants for the sensor status message framer
// Assumes: 40 MHz system clock, 32-bit APB register bus
// Notes: Message identifiers, fault bit positions, register map, timing
package ssf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Message identifier bytes
   localparam logic [7:0] ID_SELFTEST = 8'h07;
   localparam logic [7:0] ID_HEARTBEAT = 8'h0C;
   localparam logic [7:0] ID_CLEARED = 8'h0D;

   // Message lengths in bytes
   localparam logic [1:0] LEN_REPORT = 2'h3;
   localparam logic [1:0] LEN_HEARTBEAT = 2'h3;
   localparam logic [1:0] LEN_CLEARED = 2'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Fault word bit positions
   localparam int FB_IMAGE = 0;
   localparam int FB_PARAM = 1;
   localparam int FB_INT_RAM = 2;
   localparam int FB_EXT_RAM = 3;
   localparam int FB_MOTOR = 4;
   localparam int FB_SUPPLY = 5;
   localparam int FB_PHOTO_TEMP = 6;
   localparam int FB_WINDOW_TEMP = 7;
   localparam int FB_RANGE_CAL = 8;
   localparam int FB_THRESHOLD = 9;
   localparam int FB_BIAS_GAIN = 10;
   localparam int FB_SHORT_RANGE = 11;
   localparam logic [3:0] FAULT_SPARE = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Heartbeat period settings in seconds
   localparam logic [7:0] HB_MIN = 8'h0A;
   localparam logic [7:0] HB_DISABLE = 8'hFF;
   localparam logic [7:0] HB_DEFAULT = 8'h1E;

   // Timing: one heartbeat unit is one second
   localparam int CLK_HZ = 40_000_000;
   localparam int HB_UNIT_S = 1;
   localparam int SEC_CYCLES = CLK_HZ * HB_UNIT_S;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_HB_PERIOD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_FAULT = 8'h0C;
   localparam logic [7:0] REG_IRQ_STS = 8'h10;
   localparam logic [7:0] REG_IRQ_EN = 8'h14;
   localparam logic [7:0] REG_IRQ_CLR = 8'h18;

   // Control register bits
   localparam int CTRL_SELFTEST = 0;
   localparam int CTRL_HB_REQ = 1;
   localparam int CTRL_SUPPLY_CHK = 2;

   // Status register bits
   localparam int STS_BUSY = 0;
   localparam int STS_APP_HOLD = 1;
   localparam int STS_PRESENT = 2;

   // Interrupt bits
   localparam int IRQ_REPORT = 0;
   localparam int IRQ_HEARTBEAT = 1;
   localparam int IRQ_CLEARED = 2;
   localparam int IRQ_NEWFAULT = 3;
   localparam int IRQ_W = 4;

   // Any enabled sticky bit set
   function automatic logic irq_active(input logic [IRQ_W-1:0] sts, input logic [IRQ_W-1:0] en);
      irq_active = |(sts & en);
   endfunction

endpackage

// *** hdl/ssf_sec_timer.sv ***
// Purpose: Idle timer counting whole seconds since the last message
// Assumes: Synchronous active-high reset
// Notes: Fires once per idle interval, rearmed by restart
`timescale 1ns/1ps
module ssf_sec_timer import ssf_pkg::*; #(
   parameter int SEC_CYCLES_P = SEC_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Control
   input wire logic restart_i,
   input wire logic [7:0] period_i,
   // Result
   output logic expire_o
);

   logic [31:0] presc;
   logic [7:0] secs;
   logic fired;
   logic tick;

   assign tick = (presc == 32'(SEC_CYCLES_P - 1));

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler from clock cycles to seconds
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i || tick) begin
         presc <= 32'h0000_0000;
      end else begin
         presc <= presc + 32'h0000_0001;
      end
   end

   // Whole idle seconds, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         secs <= 8'h00;
      end else if (tick && secs != 8'hFF) begin
         secs <= secs + 8'h01;
      end
   end

   // One expiry per interval, never when disabled
   always_ff @(posedge clk_i) begin
      if (rst_i || restart_i) begin
         fired <= 1'b0;
         expire_o <= 1'b0;
      end else begin
         expire_o <= 1'b0;
         if (!fired && period_i != HB_DISABLE && secs >= period_i) begin
            fired <= 1'b1;
            expire_o <= 1'b1;
         end
      end
   end

   chk_no_disabled_beat: assert property (@(posedge clk_i) disable iff (rst_i)
      expire_o |-> $past(period_i) != HB_DISABLE) else $error("heartbeat expiry while disabled");

endmodule

// *** hdl/ssf_byte_tx.sv ***
// Purpose: Streams a message of up to three bytes with valid/ready
// Assumes: Sink takes a byte when valid and ready are both high
// Notes: Bytes are latched at start; done pulses after the last byte
`timescale 1ns/1ps
module ssf_byte_tx import ssf_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Message load
   input wire logic start_i,
   input wire logic [1:0] len_i,
   input wire logic [7:0] byte0_i,
   input wire logic [7:0] byte1_i,
   input wire logic [7:0] byte2_i,
   output logic idle_o,
   output logic done_o,
   // Byte stream
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i
);

   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} ssf_tx_state_t;

   ssf_tx_state_t state;
   logic [7:0] bytes [0:2];
   logic [1:0] idx;
   logic [1:0] last;
   logic [1:0] nxt;

   assign nxt = 2'(idx + 2'h1);
   assign idle_o = (state == TX_IDLE);
   assign tx_valid_o = (state == TX_SEND);

   ////////////////////////////////////////////////////////////////////////////
   // Message byte store
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bytes[0] <= 8'h00;
         bytes[1] <= 8'h00;
         bytes[2] <= 8'h00;
      end else if (start_i && state == TX_IDLE) begin
         bytes[0] <= byte0_i;
         bytes[1] <= byte1_i;
         bytes[2] <= byte2_i;
      end
   end

   // Sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= TX_IDLE;
         idx <= 2'h0;
         last <= 2'h0;
         tx_data_o <= 8'h00;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         unique case (state)
            TX_IDLE: begin
               if (start_i) begin
                  state <= TX_SEND;
                  idx <= 2'h0;
                  last <= 2'(len_i - 2'h1);
                  tx_data_o <= byte0_i;
               end
            end
            TX_SEND: begin
               if (tx_ready_i) begin
                  if (idx == last) begin
                     state <= TX_IDLE;
                     done_o <= 1'b1;
                  end else begin
                     idx <= nxt;
                     tx_data_o <= bytes[nxt];
                  end
               end
            end
         endcase
      end
   end

   chk_data_held: assert property (@(posedge clk_i) disable iff (rst_i)
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)) else $error("byte changed while stalled");

endmodule

// *** hdl/ssf_framer.sv ***
// Purpose: Sensor status message framer with APB registers and interrupt
// Assumes: 40 MHz clock, synchronous reset, byte sink with valid/ready
// Notes: Sends self-test report, heartbeat and detection-cleared messages
//
// Overview of operation
// - Send self-test report on command and whenever a new failure appears.
// - Self-test report opens with identifier byte 7.
// - Report carries one 16-bit fault word; set bit means failure.
// - Bits 0,1 flag image CRC and parameter checksum; either holds application.
// - Bit 2 internal RAM test, bit 3 external RAM test failure.
// - Bit 4 flags scanning motor speed out of tolerance.
// - Bit 5 driven only by supply check, otherwise zero.
// - Bit 6 photodiode temperature, bit 7 window temperature out of limits.
// - Bits 8,9,10 flag calibration, threshold test, bias gain failures.
// - Bit 11 flags too many readings under minimum range over three hours.
// - Heartbeat sent after a whole idle interval without messages, or on host request.
// - Heartbeat is identifier 12 plus two beam bytes, three bytes.
// - First beam byte reports second beam, next byte reports first beam.
// - One-byte message 13 sent when no vehicle remains in detection.
// - Heartbeat period 10 to 254 seconds, 255 disables; reset restores default.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module ssf_framer import ssf_pkg::*; #(
   parameter int SEC_CYCLES_P = SEC_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Self-test check results
   input wire logic image_crc_fail_i,
   input wire logic param_sum_fail_i,
   input wire logic int_ram_fail_i,
   input wire logic ext_ram_fail_i,
   input wire logic motor_speed_fail_i,
   input wire logic supply_fail_i,
   input wire logic receiver_photodiode_temp_fail_i,
   input wire logic window_temp_fail_i,
   input wire logic range_cal_fail_i,
   input wire logic threshold_test_fail_i,
   input wire logic receiver_bias_controller_gain_fail_i,
   input wire logic short_range_warning_i,
   // Detection state
   input wire logic [7:0] beam1_detect_i,
   input wire logic [7:0] beam2_detect_i,
   input wire logic vehicle_present_i,
   // Byte stream toward host link
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   // Status outputs
   output logic app_hold_o,
   output logic irq_o
);

   logic wr_en;
   logic rd_setup;
   logic mapped;
   logic [7:0] hb_period;
   logic supply_chk;
   logic [15:0] fault_word;
   logic [15:0] fault_seen;
   logic [31:0] status_word;
   logic new_fault;
   logic present_q;
   logic st_pend;
   logic hb_pend;
   logic clr_pend;
   logic tx_idle;
   logic tx_done;
   logic hb_expire;
   logic launch_st;
   logic launch_hb;
   logic launch_clr;
   logic launch;
   logic [1:0] launch_len;
   logic [7:0] launch_b0;
   logic [7:0] launch_b1;
   logic [7:0] launch_b2;
   logic [IRQ_W-1:0] irq_sts;
   logic [IRQ_W-1:0] irq_en;
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode: zero wait states, error on unmapped offsets
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_setup = psel_i && !penable_i && !pwrite_i;
   assign pready_o = 1'b1;
   always_comb begin
      unique case (paddr_i)
         REG_CTRL, REG_HB_PERIOD, REG_STATUS, REG_FAULT, REG_IRQ_STS, REG_IRQ_EN, REG_IRQ_CLR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr_o = psel_i && penable_i && !mapped;

   // Status word from named bit positions
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[STS_BUSY] = !tx_idle;
      status_word[STS_APP_HOLD] = app_hold_o;
      status_word[STS_PRESENT] = vehicle_present_i;
   end

   // Read data captured in the setup cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (rd_setup) begin
         unique case (paddr_i)
            REG_CTRL: prdata_o <= 32'(supply_chk) << CTRL_SUPPLY_CHK;
            REG_HB_PERIOD: prdata_o <= {24'h00_0000, hb_period};
            REG_STATUS: prdata_o <= status_word;
            REG_FAULT: prdata_o <= {16'h0000, fault_word};
            REG_IRQ_STS: prdata_o <= {28'h000_0000, irq_sts};
            REG_IRQ_EN: prdata_o <= {28'h000_0000, irq_en};
            default: prdata_o <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Heartbeat period, default restored by every reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hb_period <= HB_DEFAULT;
      end else if (wr_en && paddr_i == REG_HB_PERIOD && pwdata_i[7:0] >= HB_MIN) begin
         hb_period <= pwdata_i[7:0];
      end
   end

   // Supply check enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         supply_chk <= 1'b0;
      end else if (wr_en && paddr_i == REG_CTRL) begin
         supply_chk <= pwdata_i[CTRL_SUPPLY_CHK];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault word assembly
   always_comb begin
      fault_word = 16'h0000;
      fault_word[FB_IMAGE] = image_crc_fail_i;
      fault_word[FB_PARAM] = param_sum_fail_i;
      fault_word[FB_INT_RAM] = int_ram_fail_i;
      fault_word[FB_EXT_RAM] = ext_ram_fail_i;
      fault_word[FB_MOTOR] = motor_speed_fail_i;
      fault_word[FB_SUPPLY] = supply_chk && supply_fail_i;
      fault_word[FB_PHOTO_TEMP] = receiver_photodiode_temp_fail_i;
      fault_word[FB_WINDOW_TEMP] = window_temp_fail_i;
      fault_word[FB_RANGE_CAL] = range_cal_fail_i;
      fault_word[FB_THRESHOLD] = threshold_test_fail_i;
      fault_word[FB_BIAS_GAIN] = receiver_bias_controller_gain_fail_i;
      fault_word[FB_SHORT_RANGE] = short_range_warning_i;
      fault_word[15:12] = FAULT_SPARE;
   end

   // Image CRC and parameter checksum faults hold the application in the bootloader
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         app_hold_o <= 1'b0;
      end else begin
         app_hold_o <= fault_word[FB_IMAGE] || fault_word[FB_PARAM];
      end
   end

   // Newly detected failure bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fault_seen <= 16'h0000;
      end else begin
         fault_seen <= fault_word;
      end
   end
   assign new_fault = |(fault_word & ~fault_seen);

   // Vehicle presence history for the cleared edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         present_q <= 1'b0;
      end else begin
         present_q <= vehicle_present_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Message arbitration: report, then cleared, then heartbeat
   assign launch_st = tx_idle && st_pend;
   assign launch_clr = tx_idle && !st_pend && clr_pend;
   assign launch_hb = tx_idle && !st_pend && !clr_pend && hb_pend;
   assign launch = launch_st || launch_clr || launch_hb;

   // Pending requests; new request wins over launch clear; any message drops a waiting beat
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_pend <= 1'b0;
         clr_pend <= 1'b0;
         hb_pend <= 1'b0;
      end else begin
         st_pend <= (st_pend && !launch_st) || new_fault
            || (wr_en && paddr_i == REG_CTRL && pwdata_i[CTRL_SELFTEST]);
         clr_pend <= (clr_pend && !launch_clr) || (present_q && !vehicle_present_i);
         hb_pend <= (hb_pend && !launch) || hb_expire
            || (wr_en && paddr_i == REG_CTRL && pwdata_i[CTRL_HB_REQ]);
      end
   end

   // Message contents for the selected kind
   always_comb begin
      launch_len = LEN_HEARTBEAT;
      launch_b0 = ID_HEARTBEAT;
      launch_b1 = beam2_detect_i;
      launch_b2 = beam1_detect_i;
      if (launch_st) begin
         launch_len = LEN_REPORT;
         launch_b0 = ID_SELFTEST;
         launch_b1 = fault_word[15:8];
         launch_b2 = fault_word[7:0];
      end else if (launch_clr) begin
         launch_len = LEN_CLEARED;
         launch_b0 = ID_CLEARED;
         launch_b1 = 8'h00;
         launch_b2 = 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte sequencer and idle timer
   ssf_byte_tx u_tx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(launch),
      .len_i(launch_len),
      .byte0_i(launch_b0),
      .byte1_i(launch_b1),
      .byte2_i(launch_b2),
      .idle_o(tx_idle),
      .done_o(tx_done),
      .tx_valid_o(tx_valid_o),
      .tx_data_o(tx_data_o),
      .tx_ready_i(tx_ready_i)
   );

   ssf_sec_timer #(.SEC_CYCLES_P(SEC_CYCLES_P)) u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .restart_i(tx_done || (wr_en && paddr_i == REG_HB_PERIOD)),
      .period_i(hb_period),
      .expire_o(hb_expire)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: set wins over clear
   always_comb begin
      irq_set = '0;
      irq_set[IRQ_REPORT] = launch_st;
      irq_set[IRQ_HEARTBEAT] = launch_hb;
      irq_set[IRQ_CLEARED] = launch_clr;
      irq_set[IRQ_NEWFAULT] = new_fault;
   end
   assign irq_clr = (wr_en && paddr_i == REG_IRQ_CLR) ? pwdata_i[IRQ_W-1:0] : '0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_sts <= '0;
      end else begin
         irq_sts <= (irq_sts & ~irq_clr) | irq_set;
      end
   end

   // Interrupt enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_en <= '0;
      end else if (wr_en && paddr_i == REG_IRQ_EN) begin
         irq_en <= pwdata_i[IRQ_W-1:0];
      end
   end

   assign irq_o = irq_active(irq_sts, irq_en);

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   chk_report_id: assert property (@(posedge clk_i) disable iff (rst_i)
      launch_st |=> tx_valid_o && tx_data_o == ID_SELFTEST) else $error("report id wrong");

   chk_report_order: assert property (@(posedge clk_i) disable iff (rst_i)
      launch_st && tx_ready_i ##1 tx_ready_i |=> tx_valid_o && tx_data_o == $past(fault_word[15:8], 2))
      else $error("fault high byte not second");

   chk_report_low: assert property (@(posedge clk_i) disable iff (rst_i)
      launch_st ##1 tx_ready_i ##1 tx_ready_i |=> tx_data_o == $past(fault_word[7:0], 3))
      else $error("fault low byte not third");

   chk_spare_zero: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_word[15:12] == FAULT_SPARE && fault_word <= 16'h0FFF) else $error("spare fault bits set");

   chk_supply_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      !supply_chk |-> !fault_word[FB_SUPPLY]) else $error("supply bit without check");

   chk_app_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      ##1 app_hold_o == ($past(image_crc_fail_i) || $past(param_sum_fail_i))) else $error("hold mismatch");

   chk_beat_frame: assert property (@(posedge clk_i) disable iff (rst_i)
      launch_hb |=> tx_data_o == ID_HEARTBEAT && tx_valid_o) else $error("heartbeat id wrong");

   chk_beat_beams: assert property (@(posedge clk_i) disable iff (rst_i)
      launch_hb ##1 tx_ready_i |=> tx_data_o == $past(beam2_detect_i, 2)) else $error("beam two byte not first");

   chk_beat_dropped: assert property (@(posedge clk_i) disable iff (rst_i)
      (launch_st || launch_clr) && !hb_expire && !wr_en |=> !hb_pend) else $error("stale heartbeat kept");

   chk_cleared_msg: assert property (@(posedge clk_i) disable iff (rst_i)
      launch_clr ##1 tx_ready_i |-> tx_valid_o ##1 !tx_valid_o) else $error("cleared not one byte");

   chk_clear_edge: assert property (@(posedge clk_i) disable iff (rst_i)
      present_q && !vehicle_present_i |=> clr_pend) else $error("cleared request lost");

   chk_period_floor: assert property (@(posedge clk_i) disable iff (rst_i)
      hb_period >= HB_MIN) else $error("heartbeat period below floor");

   chk_fault_kick: assert property (@(posedge clk_i) disable iff (rst_i)
      new_fault |=> st_pend) else $error("new failure lost");

   chk_report_irq: assert property (@(posedge clk_i) disable iff (rst_i)
      launch_st |=> irq_sts[IRQ_REPORT]) else $error("report flag lost to clear");

   chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(irq_sts[IRQ_REPORT]) && irq_en[IRQ_REPORT] |-> irq_o) else $error("irq not raised");

endmodule

// *** tb/ssf_host_model.sv ***
// Purpose: Roadside computer model that sinks framer bytes
// Assumes: Byte taken at a rising edge with valid and ready high
// Notes: Slow mode drops ready on a pseudo-random pattern
`timescale 1ns/1ps
module ssf_host_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pacing control
   input wire logic slow_i,
   // Byte stream from the framer
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   output logic tx_ready_o
);
   logic [15:0] lfsr;
   logic [7:0] rx_q[$];

   ////////////////////////////////////////////////////////////////////////////
   // Ready pacing and byte capture
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lfsr <= 16'h0ace;
         tx_ready_o <= 1'b0;
      end else begin
         lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
         tx_ready_o <= slow_i ? lfsr[0] : 1'b1;
         if (tx_valid_i && tx_ready_o) begin
            rx_q.push_back(tx_data_i); // Bytes kept in arrival order
         end
      end
   end
endmodule

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the status message framer
// Assumes: Short second of 20 cycles, host model as byte sink
// Notes: Covers reports, heartbeats, cleared message, irq, APB
`timescale 1ns/1ps
module tb;
   import ssf_pkg::*;
   logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, veh = 0, slow = 0;
   logic [7:0] paddr_i = 0, b1 = 0, b2 = 0;
   logic [31:0] pwdata_i = 0, prdata_o, rdat, seed = 32'h7965;
   logic [11:0] flt = 0;
   logic pready_o, pslverr_o, rerr, tx_valid_o, tx_ready_i, app_hold_o, irq_o;
   logic [7:0] tx_data_o;
   int n_errors = 0, check_count = 0, n;

   always #12.5 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////////
   // Design and host model
   ssf_framer #(.SEC_CYCLES_P(20)) DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .image_crc_fail_i(flt[0]), .param_sum_fail_i(flt[1]), .int_ram_fail_i(flt[2]),
      .ext_ram_fail_i(flt[3]), .motor_speed_fail_i(flt[4]), .supply_fail_i(flt[5]),
      .receiver_photodiode_temp_fail_i(flt[6]), .window_temp_fail_i(flt[7]), .range_cal_fail_i(flt[8]),
      .threshold_test_fail_i(flt[9]), .receiver_bias_controller_gain_fail_i(flt[10]),
      .short_range_warning_i(flt[11]), .beam1_detect_i(b1), .beam2_detect_i(b2),
      .vehicle_present_i(veh), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
      .tx_ready_i(tx_ready_i), .app_hold_o(app_hold_o), .irq_o(irq_o));
   ssf_host_model host (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .tx_valid_i(tx_valid_o),
      .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected fault word: spare bits zero, supply bit only when checked
   function automatic logic [15:0] fw(input logic [11:0] f, input logic sup);
      fw = {FAULT_SPARE, f};
      fw[FB_SUPPLY] = f[FB_SUPPLY] & sup;
   endfunction
   task print_verdict();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      psel_i <= 1;
      penable_i <= 0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1;
      k = 0;
      do begin @(posedge clk_i); k++; end while (pready_o !== 1'b1 && k < 50);
      if (k >= 50) begin n_errors++; print_verdict(); end
      rdat = prdata_o;
      rerr = pslverr_o;
      psel_i <= 0;
      penable_i <= 0;
   endtask
   // Waits for one whole message and compares its bytes
   task expect_msg(input int len, input logic [7:0] x0, input logic [7:0] x1, input logic [7:0] x2);
      int k;
      logic [7:0] e[3];
      e = '{x0, x1, x2};
      k = 0;
      while (host.rx_q.size() < len && k < 2000) begin @(posedge clk_i); k++; end
      if (k >= 2000) begin n_errors++; print_verdict(); end
      repeat (3) @(posedge clk_i);
      chk(host.rx_q.size(), len, "message length");
      for (int i = 0; i < len; i++) chk(host.rx_q[i], e[i], "message byte");
      host.rx_q.delete();
   endtask
   task wait_valid(input int lim, input bit must);
      n = 0;
      while (tx_valid_o !== 1'b1 && n < lim) begin @(posedge clk_i); n++; end
      if (must && n >= lim) begin n_errors++; print_verdict(); end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [11:0] f;
      logic sup;
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      apb(0, REG_HB_PERIOD, 0);
      chk(rdat, 32'(HB_DEFAULT), "hb period after reset");
      apb(1, REG_HB_PERIOD, 32'h0000_00ff);
      apb(0, 8'h1c, 0);
      chk({rdat[30:0], rerr}, 32'h0000_0001, "unmapped read");
      apb(1, REG_IRQ_EN, 32'h0000_000f);
      for (int i = 0; i < 6; i++) begin
         sup = (i >= 4);
         f = 12'(rnd()) | (12'h001 << (rnd() % 5));
         f[FB_SUPPLY] = (i >= 3);
         slow <= i[0];
         flt <= 0;
         repeat (4) @(posedge clk_i);
         apb(1, REG_CTRL, {29'h0, sup, 2'b00});
         flt <= f;
         expect_msg(3, ID_SELFTEST, fw(f, sup) >> 8, fw(f, sup));
         chk(app_hold_o, f[0] | f[1], "application hold");
         apb(0, REG_FAULT, 0);
         chk(rdat, 32'(fw(f, sup)), "fault register");
         apb(0, REG_STATUS, 0);
         chk(rdat, {29'h0, veh, f[0] | f[1], 1'b0}, "status word");
         apb(1, REG_CTRL, {29'h0, sup, 2'b01});
         expect_msg(3, ID_SELFTEST, fw(f, sup) >> 8, fw(f, sup));
      end
      apb(0, REG_IRQ_STS, 0);
      chk({rdat[30:0], irq_o}, 32'h0000_0013, "report irq");
      apb(1, REG_IRQ_CLR, 32'h0000_000f);
      apb(0, REG_IRQ_STS, 0);
      chk({rdat[30:0], irq_o}, 32'h0000_0000, "irq cleared");
      for (int i = 0; i < 3; i++) begin
         b1 <= (i == 0) ? 8'h00 : 8'(rnd());
         b2 <= (i == 0) ? 8'hff : 8'(rnd());
         @(posedge clk_i);
         apb(1, REG_CTRL, 32'h0000_0002);
         expect_msg(3, ID_HEARTBEAT, b2, b1);
      end
      veh <= 1;
      repeat (5) @(posedge clk_i);
      veh <= 0;
      expect_msg(1, ID_CLEARED, 0, 0);
      apb(1, REG_IRQ_EN, 0);
      apb(1, REG_HB_PERIOD, 32'h0000_0005);
      apb(0, REG_HB_PERIOD, 0);
      chk(rdat, 32'h0000_00ff, "short period refused");
      apb(1, REG_HB_PERIOD, 32'h0000_000a);
      wait_valid(400, 1);
      chk(n >= 190 && n <= 215, 1, "first heartbeat delay");
      expect_msg(3, ID_HEARTBEAT, b2, b1);
      repeat (100) @(posedge clk_i);
      veh <= 1;
      repeat (5) @(posedge clk_i);
      veh <= 0;
      expect_msg(1, ID_CLEARED, 0, 0);
      wait_valid(400, 1);
      chk(n >= 190 && n <= 215, 1, "heartbeat after restart");
      expect_msg(3, ID_HEARTBEAT, b2, b1);
      apb(0, REG_IRQ_STS, 0);
      chk({rdat[30:0], irq_o}, 32'h0000_000c, "masked irq");
      apb(1, REG_HB_PERIOD, 32'h0000_00ff);
      wait_valid(700, 0);
      chk(n, 700, "heartbeat disabled");
      flt <= 0;
      rst_i <= 1;
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      apb(0, REG_HB_PERIOD, 0);
      chk(rdat, 32'(HB_DEFAULT), "hb period after second reset");
      print_verdict();
   end
endmodule
